// *** pkg/msi_cap_cfg.svh ***
// offsets, field positions, reset values and fixed codes of the capability registers
//
// Contract
// - interrupt capability low byte reads fixed identifier 0x05
// - next pointer bits 15:8 default zero, marking the end of list
// - bit 16 enables interrupt messages, read-write, resets to zero
// - one message only: capable field reads zero, granted count fixed
// - bit 23 reads one, advertising 64-bit message addresses
// - lower address keeps bits 31:2 writable, bits 1:0 read zero
// - non-zero upper address gives a 64-bit message write address
// - zero upper address gives a 32-bit address from lower register
// - message payload bits 15:0 writable, bits 31:16 read zero
// - subsystem header: fixed identifier 0x0D, loadable pointer reset zero
// - subsystem register: loadable vendor and subsystem codes, reset zero
`ifndef MSI_CAP_CFG_SVH
`define MSI_CAP_CFG_SVH

// register byte offsets
`define MSI_CAP_CONTROL_OFS   8'hD0
`define MSI_ADDRESS_LOW_OFS   8'hD4
`define MSI_ADDRESS_HIGH_OFS  8'hD8
`define MSI_MESSAGE_DATA_OFS  8'hDC
`define LOAD_UNLOCK_OFS       8'hE0
`define MSI_STATUS_OFS        8'hE4
`define SUBSYS_CAP_HEADER_OFS 8'hF0
`define SUBSYS_IDENTITY_OFS   8'hF4

// interrupt and subsystem capability fields, load gate reset
`define MSI_CAP_IDENT_VAL     8'h05
`define SUBSYS_CAP_IDENT_VAL  8'h0D
`define NEXT_PTR_RST          8'h00
`define MSI_ENABLE_BIT        16
`define MSI_CAPABLE_MSGS      3'h0
`define MSI_GRANTED_MSGS      3'h0
`define WIDE_ADDR_CAPABLE     1'h1
`define ADDR_LOW_KEEP_MASK    32'hFFFFFFFC
`define PAYLOAD_RST           16'h0000
`define SUBSYS_CODE_RST       16'h0000
`define UNLOCK_RST            1'h0

// bus transfer size accepted (word only)
`define AHB_SIZE_WORD         3'h2

`endif

// *** pkg/msi_cap_pkg.sv ***
// types shared by the capability register bank and its helpers
package msi_cap_pkg;

    // one register access handed from the bus port to the bank
    typedef struct packed {
        logic [7:0]  addr;
        logic        write;
        logic [31:0] wdata;
    } reg_access_t;

    // one interrupt memory write offered towards the root
    typedef struct packed {
        logic [63:0] addr;
        logic        wide;
        logic [31:0] data;
    } msi_write_t;

    // bus port phases
    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WAIT,
        BUS_DONE
    } bus_state_t;

endpackage

// *** design/ahb_reg_port.sv ***
// ahb-lite slave front end with one wait state per word transfer
`timescale 1ns/1ps
`include "msi_cap_cfg.svh"
module ahb_reg_port
    import msi_cap_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             acc_stb,
    output reg_access_t      acc,
    input  wire logic [31:0] rd_data
);
    bus_state_t  state_r;
    logic [7:0]  addr_r;
    logic        write_r;
    logic        take;

    // non-word sizes are answered okay with no effect
    assign take = hsel & htrans[1] & hready & (hsize == `AHB_SIZE_WORD);

    // phase tracking; back-to-back transfers allowed from done
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= BUS_IDLE;
        end else begin
            case (state_r)
                BUS_IDLE: state_r <= take ? BUS_WAIT : BUS_IDLE;
                BUS_WAIT: state_r <= BUS_DONE;
                BUS_DONE: state_r <= take ? BUS_WAIT : BUS_IDLE;
                default:  state_r <= BUS_IDLE;
            endcase
        end
    end

    // address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_r  <= 8'h00;
            write_r <= 1'b0;
        end else if (take) begin
            addr_r  <= haddr[7:0];
            write_r <= hwrite;
        end
    end

    // read data registered so hrdata never glitches
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (state_r == BUS_WAIT && !write_r) begin
            hrdata <= rd_data;
        end
    end

    // hwdata is valid during the wait cycle, so the access fires then
    assign acc_stb   = (state_r == BUS_WAIT);
    assign acc       = '{addr: addr_r, write: write_r, wdata: hwdata};
    assign hreadyout = (state_r != BUS_WAIT);
    assign hresp     = 1'b0;
endmodule // ahb_reg_port

// *** design/msi_write_former.sv ***
// builds and offers the interrupt memory write from the programmed fields
`timescale 1ns/1ps
module msi_write_former
    import msi_cap_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        enable,
    input  wire logic [31:0] addr_low,
    input  wire logic [31:0] addr_high,
    input  wire logic [15:0] payload,
    input  wire logic        raise,
    input  wire logic        msi_ready,
    output logic             msi_valid,
    output msi_write_t       msi_out,
    output logic             pending,
    output logic             sent
);
    logic launch;

    // a message is formed only when nothing is on offer
    assign launch = pending & enable & ~msi_valid;
    assign sent   = msi_valid & msi_ready;

    // pending flag: a new raise wins over the launch clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pending <= 1'b0;
        end else if (raise & enable) begin
            pending <= 1'b1;
        end else if (launch | ~enable) begin
            pending <= 1'b0;
        end
    end

    // offer held until taken; fields frozen at launch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            msi_valid <= 1'b0;
            msi_out   <= '0;
        end else if (launch) begin
            msi_valid    <= 1'b1;
            msi_out.wide <= (addr_high != 32'h00000000);
            if (addr_high != 32'h00000000) begin
                msi_out.addr <= {addr_high, addr_low};
            end else begin
                msi_out.addr <= {32'h00000000, addr_low};
            end
            msi_out.data <= {16'h0000, payload};
        end else if (sent) begin
            msi_valid <= 1'b0;
        end
    end
endmodule // msi_write_former

// *** design/msi_capability_registers.sv ***
// capability register bank for message interrupts and subsystem identity
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "msi_cap_cfg.svh"
module msi_capability_registers
    import msi_cap_pkg::*;
#(
    parameter int REG_AW = 8
)
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite register bus
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // interrupt event and message write towards the root
    input  wire logic        irq_event,
    input  wire logic        msi_ready,
    output logic             msi_valid,
    output msi_write_t       msi_write
);

    // the decoder looks at exactly one byte of offset
    if (REG_AW != 8) begin : g_bad_aw
        $error("REG_AW must be 8");
    end

    // bus side signals
    logic        acc_stb;
    reg_access_t acc;
    logic [31:0] rd_data;
    logic        wr_stb;

    // interrupt capability state
    logic        msi_enable_r;
    logic [7:0]  msi_next_ptr_r;
    logic [31:0] msi_addr_low_r;
    logic [31:0] msi_addr_high_r;
    logic [15:0] msi_payload_r;

    // subsystem capability state
    logic [7:0]  subsys_next_ptr_r;
    logic [15:0] subsystem_vendor_code_r;
    logic [15:0] subsystem_code_r;

    // load gate and status
    logic        load_unlock_r;
    logic        msg_pending;
    logic        msg_sent;
    logic [7:0]  sent_count_r;
    logic [7:0]  sent_count_nxt;

    // register views as read back
    logic [31:0] cap_control_view;
    logic [31:0] addr_low_view;
    logic [31:0] payload_view;
    logic [31:0] subsys_header_view;
    logic [31:0] subsys_identity_view;
    logic [31:0] status_view;
    logic [31:0] unlock_view;

    // per-register write selects
    logic        wr_cap_control;
    logic        wr_addr_low;
    logic        wr_addr_high;
    logic        wr_payload;
    logic        wr_unlock;
    logic        wr_status;
    logic        wr_subsys_header;
    logic        wr_subsys_identity;

    // bus slave front end
    ahb_reg_port u_port (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .acc_stb   (acc_stb),
        .acc       (acc),
        .rd_data   (rd_data)
    );

    assign wr_stb = acc_stb & acc.write;

    // write decode; unmapped offsets select nothing
    always_comb begin
        wr_cap_control     = 1'b0;
        wr_addr_low        = 1'b0;
        wr_addr_high       = 1'b0;
        wr_payload         = 1'b0;
        wr_unlock          = 1'b0;
        wr_status          = 1'b0;
        wr_subsys_header   = 1'b0;
        wr_subsys_identity = 1'b0;
        if (!wr_stb) begin
            wr_cap_control = 1'b0;
        end else if (acc.addr == `MSI_CAP_CONTROL_OFS) begin
            wr_cap_control = 1'b1;
        end else if (acc.addr == `MSI_ADDRESS_LOW_OFS) begin
            wr_addr_low = 1'b1;
        end else if (acc.addr == `MSI_ADDRESS_HIGH_OFS) begin
            wr_addr_high = 1'b1;
        end else if (acc.addr == `MSI_MESSAGE_DATA_OFS) begin
            wr_payload = 1'b1;
        end else if (acc.addr == `LOAD_UNLOCK_OFS) begin
            wr_unlock = 1'b1;
        end else if (acc.addr == `MSI_STATUS_OFS) begin
            wr_status = 1'b1;
        end else if (acc.addr == `SUBSYS_CAP_HEADER_OFS) begin
            wr_subsys_header = 1'b1;
        end else if (acc.addr == `SUBSYS_IDENTITY_OFS) begin
            wr_subsys_identity = 1'b1;
        end
    end

    // interrupt enable; bit 16 of the control word, the only bit stored while the load gate is closed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            msi_enable_r <= 1'b0;
        end else if (wr_cap_control) begin
            msi_enable_r <= acc.wdata[`MSI_ENABLE_BIT];
        end
    end

    // loadable pointer: written only while the load gate is open,
    // so plain configuration writes cannot break the capability list
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            msi_next_ptr_r <= `NEXT_PTR_RST;
        end else if (wr_cap_control && load_unlock_r) begin
            msi_next_ptr_r <= acc.wdata[15:8];
        end
    end

    // lower message address, dword aligned
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            msi_addr_low_r <= 32'h00000000;
        end else if (wr_addr_low) begin
            msi_addr_low_r <= acc.wdata & `ADDR_LOW_KEEP_MASK;
        end
    end

    // upper message address, all bits stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            msi_addr_high_r <= 32'h00000000;
        end else if (wr_addr_high) begin
            msi_addr_high_r <= acc.wdata;
        end
    end

    // message payload, low half only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            msi_payload_r <= `PAYLOAD_RST;
        end else if (wr_payload) begin
            msi_payload_r <= acc.wdata[15:0];
        end
    end

    // load gate for the loadable fields
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            load_unlock_r <= `UNLOCK_RST;
        end else if (wr_unlock) begin
            load_unlock_r <= acc.wdata[0];
        end
    end

    // subsystem capability pointer, loadable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            subsys_next_ptr_r <= `NEXT_PTR_RST;
        end else if (wr_subsys_header && load_unlock_r) begin
            subsys_next_ptr_r <= acc.wdata[15:8];
        end
    end

    // subsystem codes, loadable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            subsystem_vendor_code_r <= `SUBSYS_CODE_RST;
            subsystem_code_r        <= `SUBSYS_CODE_RST;
        end else if (wr_subsys_identity && load_unlock_r) begin
            subsystem_vendor_code_r <= acc.wdata[15:0];
            subsystem_code_r        <= acc.wdata[31:16];
        end
    end

    // sent counter; a send in the clearing cycle still counts
    always_comb begin
        sent_count_nxt = sent_count_r;
        if (wr_status) begin
            sent_count_nxt = 8'h00;
        end
        if (msg_sent) begin
            sent_count_nxt = sent_count_nxt + 8'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sent_count_r <= 8'h00;
        end else begin
            sent_count_r <= sent_count_nxt;
        end
    end

    // message write builder
    msi_write_former u_former (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .enable    (msi_enable_r),
        .addr_low  (msi_addr_low_r),
        .addr_high (msi_addr_high_r),
        .payload   (msi_payload_r),
        .raise     (irq_event),
        .msi_ready (msi_ready),
        .msi_valid (msi_valid),
        .msi_out   (msi_write),
        .pending   (msg_pending),
        .sent      (msg_sent)
    );

    // control word: fixed identifier, single message, wide capable
    assign cap_control_view = {
        8'h00,
        `WIDE_ADDR_CAPABLE,
        `MSI_GRANTED_MSGS,
        `MSI_CAPABLE_MSGS,
        msi_enable_r,
        msi_next_ptr_r,
        `MSI_CAP_IDENT_VAL
    };

    // lower address: low two bits never set
    assign addr_low_view = msi_addr_low_r & `ADDR_LOW_KEEP_MASK;

    // payload with a zero upper half
    assign payload_view = {16'h0000, msi_payload_r};

    // subsystem header: identifier plus loadable pointer
    assign subsys_header_view = {16'h0000, subsys_next_ptr_r, `SUBSYS_CAP_IDENT_VAL};

    // subsystem identity word
    assign subsys_identity_view = {subsystem_code_r, subsystem_vendor_code_r};

    // status: pending, offer on bus, wide form in use, sent count
    assign status_view = {
        16'h0000,
        sent_count_r,
        5'h00,
        msi_addr_high_r != 32'h00000000,
        msi_valid,
        msg_pending
    };

    assign unlock_view = {31'h00000000, load_unlock_r};

    // read mux; unmapped offsets read as zero
    always_comb begin
        rd_data = 32'h00000000;
        if (acc.addr == `MSI_CAP_CONTROL_OFS) begin
            rd_data = cap_control_view;
        end else if (acc.addr == `MSI_ADDRESS_LOW_OFS) begin
            rd_data = addr_low_view;
        end else if (acc.addr == `MSI_ADDRESS_HIGH_OFS) begin
            rd_data = msi_addr_high_r;
        end else if (acc.addr == `MSI_MESSAGE_DATA_OFS) begin
            rd_data = payload_view;
        end else if (acc.addr == `LOAD_UNLOCK_OFS) begin
            rd_data = unlock_view;
        end else if (acc.addr == `MSI_STATUS_OFS) begin
            rd_data = status_view;
        end else if (acc.addr == `SUBSYS_CAP_HEADER_OFS) begin
            rd_data = subsys_header_view;
        end else if (acc.addr == `SUBSYS_IDENTITY_OFS) begin
            rd_data = subsys_identity_view;
        end
    end

    // limitation: the message address is trusted to route to the root;
    // a stray address gives undefined delivery

endmodule // msi_capability_registers

// *** testbench/msi_cap_checker_properties.sv ***
// concurrent checks on the ports of the capability register bank
`timescale 1ns/1ps
`include "msi_cap_cfg.svh"
module msi_cap_checker
    import msi_cap_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        msi_ready,
    input wire logic        msi_valid,
    input wire msi_write_t  msi_write
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // word read taken this edge; data stands two edges later
    logic rd_req;
    assign rd_req = hsel && htrans[1] && hready && !hwrite && hsize == `AHB_SIZE_WORD;

    AST_CAP_IDENT: assert property (rd_req && haddr[7:0] == `MSI_CAP_CONTROL_OFS
        |-> ##2 (hreadyout && hrdata[7:0] == `MSI_CAP_IDENT_VAL))
        else $error("interrupt capability identifier wrong");
    AST_CAP_FIXED: assert property (rd_req && haddr[7:0] == `MSI_CAP_CONTROL_OFS
        |-> ##2 (hrdata[31:23] == 9'h001 && hrdata[22:17] == 6'h00))
        else $error("fixed capability fields wrong");
    AST_SUB_IDENT: assert property (rd_req && haddr[7:0] == `SUBSYS_CAP_HEADER_OFS
        |-> ##2 (hrdata[7:0] == `SUBSYS_CAP_IDENT_VAL && hrdata[31:16] == 16'h0000))
        else $error("subsystem identifier wrong");
    AST_PAYLOAD_TOP: assert property (rd_req && haddr[7:0] == `MSI_MESSAGE_DATA_OFS
        |-> ##2 hrdata[31:16] == 16'h0000)
        else $error("payload upper half not zero");
    AST_ADDR_ALIGN: assert property (rd_req && haddr[7:0] == `MSI_ADDRESS_LOW_OFS
        |-> ##2 hrdata[1:0] == 2'h0)
        else $error("low address bits not zero");
    AST_WIDE: assert property (msi_valid && msi_write.addr[63:32] != 32'h0 |-> msi_write.wide)
        else $error("wide flag missing for upper address");
    AST_NARROW: assert property (msi_valid && msi_write.addr[63:32] == 32'h0
        |-> (!msi_write.wide && msi_write.addr[1:0] == 2'h0))
        else $error("narrow write malformed");
    AST_DATA_TOP: assert property (msi_valid |-> msi_write.data[31:16] == 16'h0000)
        else $error("message data upper half not zero");
    AST_OFFER_HOLD: assert property (msi_valid && !msi_ready
        |=> (msi_valid && $stable(msi_write)))
        else $error("offer dropped or changed before acceptance");
endmodule // msi_cap_checker

bind msi_capability_registers msi_cap_checker chk_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hready, .hreadyout, .hrdata, .msi_ready, .msi_valid, .msi_write);

// *** testbench/root_msi_sink.sv ***
// root side model that accepts interrupt message writes after a set stall
`timescale 1ns/1ps
module root_msi_sink
    import msi_cap_pkg::*;
(
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic [3:0] stall,
    input wire logic       msi_valid,
    input wire msi_write_t msi_write,
    output logic           msi_ready,
    output msi_write_t     last_write,
    output logic [7:0]     taken
);
    logic [3:0] wait_r;

    // ready only after stall cycles of a standing offer, dropped after each take
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            msi_ready  <= 1'b0;
            wait_r     <= 4'h0;
            taken      <= 8'h00;
            last_write <= '0;
        end else if (msi_valid && msi_ready) begin
            last_write <= msi_write; // address routes to root by programming
            taken      <= taken + 8'h01;
            msi_ready  <= 1'b0;
            wait_r     <= 4'h0;
        end else if (msi_valid) begin
            if (wait_r >= stall) begin
                msi_ready <= 1'b1;
            end else begin
                wait_r <= wait_r + 4'h1;
            end
        end
    end
endmodule // root_msi_sink

// *** testbench/msi_capability_registers_bench.sv ***
// self-checking bench for the capability register bank
`timescale 1ns/1ps
`include "msi_cap_cfg.svh"
module msi_capability_registers_bench
    import msi_cap_pkg::*;
;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq_event;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  stall;
    logic        msi_ready, msi_valid;
    msi_write_t  msi_write, last_write;
    logic [7:0]  taken;
    int          miscompares = 0;
    int          checks = 0;

    // single slave, so its ready is the bus ready
    assign hready = hreadyout;

    msi_capability_registers #(.REG_AW(8)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .irq_event(irq_event), .msi_ready(msi_ready), .msi_valid(msi_valid),
        .msi_write(msi_write));
    root_msi_sink root (.hclk(hclk), .hresetn(hresetn), .stall(stall), .msi_valid(msi_valid),
        .msi_write(msi_write), .msi_ready(msi_ready), .last_write(last_write), .taken(taken));

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    task automatic close_out();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one word transfer; called just after a rising edge, holds until ready
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] junk;
        xfer(a, 1'b1, d, junk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        xfer(a, 1'b0, 32'h00000000, v);
        chk(v, exp);
    endtask

    // event held high for n edges
    task automatic pulse(input int n);
        irq_event <= 1'b1;
        repeat (n) @(posedge hclk);
        irq_event <= 1'b0;
    endtask

    task automatic t_reset_vals();
        rd_chk(`MSI_CAP_CONTROL_OFS, 32'h00800005);
        rd_chk(`MSI_ADDRESS_LOW_OFS, 32'h00000000);
        rd_chk(`MSI_ADDRESS_HIGH_OFS, 32'h00000000);
        rd_chk(`MSI_MESSAGE_DATA_OFS, 32'h00000000);
        rd_chk(`SUBSYS_CAP_HEADER_OFS, 32'h0000000D);
        rd_chk(`SUBSYS_IDENTITY_OFS, 32'h00000000);
        $display("reset values done");
    endtask

    task automatic t_fields();
        wr(`MSI_CAP_CONTROL_OFS, 32'hFFFFFFFF);
        rd_chk(`MSI_CAP_CONTROL_OFS, 32'h00810005);
        wr(`MSI_ADDRESS_LOW_OFS, 32'hFFFFFFFF);
        rd_chk(`MSI_ADDRESS_LOW_OFS, 32'hFFFFFFFC);
        wr(`MSI_ADDRESS_HIGH_OFS, 32'hA5A55A5A);
        rd_chk(`MSI_ADDRESS_HIGH_OFS, 32'hA5A55A5A);
        wr(`MSI_MESSAGE_DATA_OFS, 32'hFFFFFFFF);
        rd_chk(`MSI_MESSAGE_DATA_OFS, 32'h0000FFFF);
        // a byte-sized write is answered but must leave the payload alone
        hsize <= 3'h0;
        wr(`MSI_MESSAGE_DATA_OFS, 32'h00000000);
        hsize <= `AHB_SIZE_WORD;
        rd_chk(`MSI_MESSAGE_DATA_OFS, 32'h0000FFFF);
        wr(`MSI_CAP_CONTROL_OFS, 32'h00000000);
        rd_chk(`MSI_CAP_CONTROL_OFS, 32'h00800005);
        wr(8'hC8, 32'hFFFFFFFF);
        rd_chk(8'hC8, 32'h00000000);
        $display("field access done");
    endtask

    task automatic t_loadable();
        wr(`SUBSYS_CAP_HEADER_OFS, 32'hFFFFFFFF);
        rd_chk(`SUBSYS_CAP_HEADER_OFS, 32'h0000000D);
        wr(`SUBSYS_IDENTITY_OFS, 32'h12345678);
        rd_chk(`SUBSYS_IDENTITY_OFS, 32'h00000000);
        wr(`LOAD_UNLOCK_OFS, 32'h00000001);
        wr(`SUBSYS_CAP_HEADER_OFS, 32'hFFFFAB00);
        rd_chk(`SUBSYS_CAP_HEADER_OFS, 32'h0000AB0D);
        wr(`SUBSYS_IDENTITY_OFS, 32'h12345678);
        rd_chk(`SUBSYS_IDENTITY_OFS, 32'h12345678);
        wr(`MSI_CAP_CONTROL_OFS, 32'h00003300);
        rd_chk(`MSI_CAP_CONTROL_OFS, 32'h00803305);
        wr(`LOAD_UNLOCK_OFS, 32'h00000000);
        $display("loadable fields done");
    endtask

    // program, raise one event and judge what the root received
    task automatic t_send(input logic [31:0] high, input logic [3:0] st, input logic w);
        logic [7:0] n0;
        n0 = taken;
        stall <= st;
        wr(`MSI_ADDRESS_LOW_OFS, 32'hFEE01003);
        wr(`MSI_ADDRESS_HIGH_OFS, high);
        wr(`MSI_MESSAGE_DATA_OFS, 32'h1234BEEF);
        wr(`MSI_CAP_CONTROL_OFS, 32'h00010000);
        pulse(1);
        for (int i = 0; i < 40 && taken != n0 + 8'h01; i++) @(posedge hclk);
        chk({24'h0, taken}, {24'h0, n0 + 8'h01});
        chk(last_write.addr[63:32], high);
        chk(last_write.addr[31:0], 32'hFEE01000);
        chk({31'h0, last_write.wide}, {31'h0, w});
        chk(last_write.data, 32'h0000BEEF);
        $display("message send done");
    endtask

    // events on back-to-back edges give two messages; none once disabled
    task automatic t_burst_off();
        logic [7:0] n0;
        n0 = taken;
        stall <= 4'h2;
        pulse(2);
        for (int i = 0; i < 60 && taken != n0 + 8'h02; i++) @(posedge hclk);
        chk({24'h0, taken}, {24'h0, n0 + 8'h02});
        wr(`MSI_CAP_CONTROL_OFS, 32'h00000000);
        pulse(1);
        repeat (12) @(posedge hclk);
        chk({24'h0, taken}, {24'h0, n0 + 8'h02});
        // four messages so far, nothing pending or offered, narrow form
        rd_chk(`MSI_STATUS_OFS, 32'h00000400);
        wr(`MSI_STATUS_OFS, 32'h00000000);
        rd_chk(`MSI_STATUS_OFS, 32'h00000000);
        $display("burst and disable done");
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = `AHB_SIZE_WORD;
        hwdata = 32'h00000000;
        irq_event = 1'b0;
        stall = 4'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset_vals();
        t_fields();
        t_loadable();
        t_send(32'h00000002, 4'h3, 1'b1);
        t_send(32'h00000000, 4'h0, 1'b0);
        t_burst_off();
        close_out();
    end

    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        #200000;
        miscompares++;
        $display("BAD %0t watchdog expired", $time);
        close_out();
    end
endmodule // msi_capability_registers_bench
